// file: sbw_core.sv
// serial port core: wake arm, break transmit, synchronous master transmit
// assumes one 100 MHz clock, a plain register port and external pad logic
`timescale 1ns/1ps
`include "sbw_defs.svh"
module sbw_core
  import sbw_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic             CLK,
  input  wire logic             RSTN,
  input  wire logic [3:0]       ADDR,
  input  wire sbw_pkg::sbw_byte_t WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [7:0]       RDATA,
  input  wire logic             RX_IN,
  output logic                  TX_CK_OUT,
  output logic                  TX_CK_OE,
  output logic                  DT_OUT,
  output logic                  DT_OE
);
  import sbw_pkg::*;

  logic       rst_a_r;
  logic       rst_n;
  logic [2:0] rx_pipe_r;
  logic       rx_lvl_r;
  logic       rx_prev_r;
  sbw_byte_t  pie_r;
  sbw_byte_t  ipr_r;
  logic       port_en_r;
  logic       rx9_r;
  logic       sren_r;
  logic       cren_r;
  logic       adden_r;
  logic       ferr_r;
  logic       rx9d_r;
  sbw_byte_t  rx_hold_r;
  logic       rx_flag_r;
  sbw_byte_t  tx_hold_r;
  logic       hold_full_r;
  logic       master_r;
  logic       tx9_r;
  logic       tx_on_r;
  logic       sync_r;
  logic       brk_r;
  logic       fast_r;
  logic       ninth_transmit_bit_r;
  logic       ck_high_r;
  logic       wide_r;
  logic       wake_r;
  logic       abd_r;
  logic       wake_seen_r;
  sbw_byte_t  div_hi_r;
  sbw_byte_t  div_lo_r;
  logic [DIV_W-1:0] baud_cnt_r;
  logic       baud_tick;
  logic [4:0] presc;
  logic [4:0] tx_pre_r;
  logic       phase_r;
  logic       tx_bit;
  logic       sync_frame;
  sbw_tx_e    tx_st_r;
  logic [11:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic       tx_brk_r;
  logic       tx_load;
  logic       tx_busy;
  sbw_rx_e    rx_st_r;
  logic [4:0] rx_cnt_r;
  logic [8:0] rx_sh_r;
  logic [3:0] rx_left_r;
  logic       rx_busy;
  logic       rx_sample;
  logic       rx_run;
  logic       fall;
  logic       rise;
  logic       wr_reg;
  logic       rd_reg;

  // true when a strobe targets a given register index
  function automatic logic hit(input logic s, input logic [3:0] a, input logic [3:0] k);
    hit = s && (a == k);
  endfunction : hit

  // reset release through two flops
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rst_a_r <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      rst_a_r <= 1'b1;
      rst_n   <= rst_a_r;
    end
  end

  // receive pin filter: level moves only when stages two and three agree
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_pipe_r <= 3'b111;
      rx_lvl_r  <= 1'b1;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_pipe_r <= {rx_pipe_r[1:0], RX_IN};
      if (rx_pipe_r[1] == rx_pipe_r[2])
        rx_lvl_r <= rx_pipe_r[2];
      rx_prev_r <= rx_lvl_r;
    end
  end

  assign fall = rx_prev_r && !rx_lvl_r;
  assign rise = !rx_prev_r && rx_lvl_r;

  // divisor tick; narrow mode uses only the low byte
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      baud_cnt_r <= '0;
    else if (!port_en_r || baud_cnt_r == '0)
      baud_cnt_r <= DIV_W'(wide_r ? {div_hi_r, div_lo_r} : {8'h00, div_lo_r});
    else
      baud_cnt_r <= baud_cnt_r - 1'b1;
  end

  assign baud_tick = port_en_r && (baud_cnt_r == '0);
  assign presc = (fast_r && wide_r) ? `SBW_PRE_FAST :
                 (fast_r || wide_r) ? `SBW_PRE_MID : `SBW_PRE_SLOW;

  // busy terms; half duplex gating in sync mode
  assign tx_busy = (tx_st_r != SBW_TX_IDLE);
  assign rx_busy = (rx_st_r != SBW_RX_IDLE);
  assign tx_load = (tx_st_r == SBW_TX_IDLE) && hold_full_r && tx_on_r && port_en_r &&
                   !(sync_r && rx_busy);
  assign rx_run  = port_en_r && cren_r && !sync_r && !wake_r &&
                   !(sync_r && tx_busy);

  // bit pacing: async counts prescaled ticks, sync uses two half periods
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_pre_r <= 5'h00;
      phase_r  <= 1'b0;
    end
    else if (tx_load || !tx_busy)
    begin
      tx_pre_r <= 5'h00;
      phase_r  <= 1'b0;
    end
    else if (baud_tick)
    begin
      // async: first tick after load aligns the start bit, else it could be cut short
      phase_r  <= sync_frame ? !phase_r : 1'b1;
      tx_pre_r <= (!phase_r || tx_pre_r == presc - 5'h01) ? 5'h00 : tx_pre_r + 5'h01;
    end
  end

  // break frames keep async framing even in sync mode
  assign sync_frame = sync_r && !tx_brk_r;
  assign tx_bit     = baud_tick && phase_r && (sync_frame || tx_pre_r == presc - 5'h01);

  // transmit shifter: loads one cycle after a word is waiting
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_r   <= SBW_TX_IDLE;
      tx_sh_r   <= 12'h000;
      tx_left_r <= 4'h0;
      tx_brk_r  <= 1'b0;
    end
    else if (!tx_on_r || !port_en_r)
      tx_st_r <= SBW_TX_IDLE;
    else if (tx_load)
    begin
      tx_brk_r  <= brk_r;
      tx_sh_r   <= brk_r ? 12'h000 : {3'b000, ninth_transmit_bit_r, tx_hold_r};
      tx_left_r <= brk_r ? `SBW_BRK_BITS : (tx9_r ? `SBW_LEN9 : `SBW_LEN8);
      tx_st_r   <= (sync_r && master_r && !brk_r) ? SBW_TX_DATA : SBW_TX_START;
    end
    else if (tx_bit)
    begin
      case (tx_st_r)
        SBW_TX_START:
          tx_st_r <= SBW_TX_DATA;
        SBW_TX_DATA:
        begin
          tx_sh_r   <= {1'b0, tx_sh_r[11:1]};
          tx_left_r <= tx_left_r - 4'h1;
          if (tx_left_r == 4'h1)
            tx_st_r <= (sync_r && !tx_brk_r) ? SBW_TX_IDLE : SBW_TX_STOP;
        end
        SBW_TX_STOP:
          tx_st_r <= SBW_TX_IDLE;
        default:
          tx_st_r <= SBW_TX_IDLE;
      endcase
    end
  end

  // pad drive: clock and data in sync master, line and input otherwise
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      TX_CK_OUT <= 1'b1;
      TX_CK_OE  <= 1'b0;
      DT_OUT    <= 1'b1;
      DT_OE     <= 1'b0;
    end
    else if (sync_r && master_r && !(tx_brk_r && tx_busy)) // stale break flag ignored when idle
    begin
      TX_CK_OE  <= port_en_r;
      TX_CK_OUT <= (tx_st_r == SBW_TX_DATA && !phase_r) ? !ck_high_r : ck_high_r;
      DT_OE     <= port_en_r && tx_busy;
      DT_OUT    <= (tx_st_r == SBW_TX_DATA) ? tx_sh_r[0] : 1'b1;
    end
    else
    begin
      TX_CK_OE  <= port_en_r;
      TX_CK_OUT <= (tx_st_r == SBW_TX_START) ? !phase_r :
                   (tx_st_r == SBW_TX_DATA) ? tx_sh_r[0] : 1'b1;
      DT_OE     <= 1'b0;
      DT_OUT    <= 1'b1;
    end
  end

  // async receiver, mid-bit sampling from the start edge
  assign rx_sample = baud_tick && (rx_cnt_r == 5'h00);

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_r   <= SBW_RX_IDLE;
      rx_cnt_r  <= 5'h00;
      rx_sh_r   <= 9'h000;
      rx_left_r <= 4'h0;
    end
    else if (!rx_run)
      rx_st_r <= SBW_RX_IDLE;
    else if (rx_st_r == SBW_RX_IDLE)
    begin
      if (fall)
      begin
        rx_st_r  <= SBW_RX_START;
        rx_cnt_r <= {1'b0, presc[4:1]};
      end
    end
    else if (baud_tick)
    begin
      rx_cnt_r <= (rx_cnt_r == 5'h00) ? presc - 5'h01 : rx_cnt_r - 5'h01;
      if (rx_sample)
      begin
        case (rx_st_r)
          SBW_RX_START:
          begin
            rx_st_r   <= rx_lvl_r ? SBW_RX_IDLE : SBW_RX_DATA;
            rx_left_r <= rx9_r ? `SBW_LEN9 : `SBW_LEN8;
          end
          SBW_RX_DATA:
          begin
            rx_sh_r   <= {rx_lvl_r, rx_sh_r[8:1]};
            rx_left_r <= rx_left_r - 4'h1;
            if (rx_left_r == 4'h1)
              rx_st_r <= SBW_RX_STOP;
          end
          SBW_RX_STOP:
            rx_st_r <= SBW_RX_IDLE;
          default:
            rx_st_r <= SBW_RX_IDLE;
        endcase
      end
    end
  end

  // register strobes
  assign wr_reg = WR && !RD;
  assign rd_reg = RD && !WR;

  // receive holding, error and flag; a new event beats the read clear
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_hold_r   <= `SBW_RST_BYTE;
      rx_flag_r   <= 1'b0;
      rx9d_r      <= 1'b0;
      ferr_r      <= 1'b0;
    end
    else
    begin
      if (rx_run && rx_sample && rx_st_r == SBW_RX_STOP)
      begin
        rx_hold_r <= rx9_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
        rx9d_r    <= rx9_r && rx_sh_r[8];
        ferr_r    <= !rx_lvl_r;
        rx_flag_r <= 1'b1;
      end
      else if (wake_r && !wake_seen_r && fall)
        rx_flag_r <= 1'b1;
      else if (hit(rd_reg, ADDR, `SBW_A_RX_HOLDING))
        rx_flag_r <= 1'b0;
    end
  end

  // wake arm: falling edge marks the event, following rise disarms
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_r      <= 1'b0;
      wake_seen_r <= 1'b0;
    end
    else if (hit(wr_reg, ADDR, `SBW_A_BAUD_CTL))
    begin
      wake_r      <= WDATA[`SBW_B_WAKE];
      wake_seen_r <= 1'b0;
    end
    else if (wake_r && !wake_seen_r && fall)
      wake_seen_r <= 1'b1;
    else if (wake_r && wake_seen_r && rise)
    begin
      wake_r      <= 1'b0;
      wake_seen_r <= 1'b0;
    end
  end

  // holding buffer: a data write fills it, the shifter load empties it
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_hold_r   <= `SBW_RST_BYTE;
      hold_full_r <= 1'b0;
    end
    else if (hit(wr_reg, ADDR, `SBW_A_TX_HOLDING))
    begin
      tx_hold_r   <= WDATA;
      hold_full_r <= 1'b1;
    end
    else if (tx_load || !tx_on_r)
      hold_full_r <= 1'b0;
  end

  // transmit control; software setting the break bit wins over the clear
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {master_r, tx9_r, tx_on_r, sync_r, brk_r, fast_r, ninth_transmit_bit_r} <= 7'h00;
    end
    else if (hit(wr_reg, ADDR, `SBW_A_TX_STATCTL))
    begin
      master_r <= WDATA[`SBW_B_MASTER];
      tx9_r    <= WDATA[`SBW_B_TX9];
      tx_on_r  <= WDATA[`SBW_B_TX_ON];
      sync_r   <= WDATA[`SBW_B_SYNC];
      brk_r    <= WDATA[`SBW_B_BRK];
      fast_r   <= WDATA[`SBW_B_FAST];
      ninth_transmit_bit_r   <= WDATA[`SBW_B_NINTH_TRANSMIT_BIT];
    end
    else if (tx_bit && tx_brk_r && tx_st_r == SBW_TX_STOP)
      brk_r <= 1'b0;
  end

  // plain storage registers
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pie_r <= `SBW_RST_BYTE;
      ipr_r <= `SBW_RST_BYTE;
      div_hi_r <= `SBW_RST_BYTE;
      div_lo_r <= `SBW_RST_BYTE;
      {port_en_r, rx9_r, sren_r, cren_r, adden_r} <= 5'h00;
      {ck_high_r, wide_r, abd_r} <= 3'b000;
    end
    else if (wr_reg)
    begin
      case (ADDR)
        `SBW_A_INT_ENABLES: pie_r <= WDATA;
        `SBW_A_INT_PRIO:    ipr_r <= WDATA;
        `SBW_A_BAUD_HI:     div_hi_r <= WDATA;
        `SBW_A_BAUD_LO:     div_lo_r <= WDATA;
        `SBW_A_RX_STATCTL:
        begin
          port_en_r <= WDATA[`SBW_B_PORT_EN];
          rx9_r     <= WDATA[`SBW_B_RX9];
          sren_r    <= WDATA[`SBW_B_SREN];
          cren_r    <= WDATA[`SBW_B_CREN];
          adden_r   <= WDATA[`SBW_B_ADDEN];
        end
        `SBW_A_BAUD_CTL:
        begin
          ck_high_r <= WDATA[`SBW_B_CK_HIGH];
          wide_r    <= WDATA[`SBW_B_WIDE];
          abd_r     <= WDATA[`SBW_B_ABD];
        end
        default: ;
      endcase
    end
  end

  // read data only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      RDATA <= `SBW_RST_BYTE;
    else if (!rd_reg)
      RDATA <= `SBW_RST_BYTE;
    else
    begin
      case (ADDR)
        `SBW_A_INT_FLAGS:
          RDATA <= {2'b00, rx_flag_r, tx_on_r && !hold_full_r, 4'h0};
        `SBW_A_INT_ENABLES: RDATA <= pie_r;
        `SBW_A_INT_PRIO:    RDATA <= ipr_r;
        `SBW_A_RX_STATCTL:
          RDATA <= {port_en_r, rx9_r, sren_r, cren_r, adden_r, ferr_r, 1'b0, rx9d_r};
        `SBW_A_RX_HOLDING:  RDATA <= rx_hold_r;
        `SBW_A_TX_HOLDING:  RDATA <= tx_hold_r;
        `SBW_A_TX_STATCTL:
          RDATA <= {master_r, tx9_r, tx_on_r, sync_r, brk_r, fast_r,
                    !tx_busy, ninth_transmit_bit_r};
        `SBW_A_BAUD_CTL:
          RDATA <= {1'b0, !rx_busy, 1'b0, ck_high_r, wide_r, 1'b0, wake_r, abd_r};
        `SBW_A_BAUD_HI:     RDATA <= div_hi_r;
        `SBW_A_BAUD_LO:     RDATA <= div_lo_r;
        default:            RDATA <= `SBW_RST_BYTE;
      endcase
    end
  end

endmodule : sbw_core

// file: sbw_core_assertions.sv
// port-level checker for the serial port core
// assumes control bytes change only through software writes it can see
`timescale 1ns/1ps
module sbw_core_checker
  import sbw_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic               CLK,
  input wire logic               RSTN,
  input wire logic [3:0]         ADDR,
  input wire sbw_pkg::sbw_byte_t WDATA,
  input wire logic               WR,
  input wire logic               RD,
  input wire logic [7:0]         RDATA,
  input wire logic               RX_IN,
  input wire logic               TX_CK_OUT,
  input wire logic               TX_CK_OE,
  input wire logic               DT_OUT,
  input wire logic               DT_OE
);
  logic [7:0] cfg_r [0:9];
  logic [7:0] exp_r;
  logic [3:0] age_r;
  logic       sync_m;
  logic       ck_hi;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // shadow of software writes; hardware-cleared bits are never used
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < 10; i++)
        cfg_r[i] <= 8'h00;
    end
    else if (WR && ADDR <= 4'h9)
      cfg_r[ADDR] <= WDATA;
  end
  // cycles since any write, so mode changes have settled
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      age_r <= 4'h0;
    else if (WR)
      age_r <= 4'h0;
    else if (age_r != 4'hf)
      age_r <= age_r + 4'h1;
  end
  // expected read value of plain storage bytes
  always_ff @(posedge CLK)
  begin
    if (RD && ADDR <= 4'h9)
      exp_r <= cfg_r[ADDR];
  end
  assign sync_m = cfg_r[3][7] & cfg_r[6][7] & cfg_r[6][4];
  assign ck_hi  = cfg_r[7][4];
  sequence s_quiet;
    sync_m && age_r == 4'hf && !DT_OE;
  endsequence
  sequence s_rd_busy;
    RD && ADDR == 4'h6 && DT_OE ##1 DT_OE;
  endsequence
  sequence s_rd_idle;
    RD && ADDR == 4'h6 && sync_m && age_r == 4'hf && !DT_OE ##1 !DT_OE;
  endsequence
  AST_UNMAPPED: assert property (RD && ADDR > 4'h9 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_STORE: assert property ((RD && (ADDR == 4'h1 || ADDR == 4'h2 || ADDR == 4'h8
    || ADDR == 4'h9)) |=> RDATA == exp_r)
    else $error("storage byte read back wrong");
  AST_PORT_OE: assert property ($rose(cfg_r[3][7]) |-> ##[1:3] TX_CK_OE)
    else $error("clock pin not claimed");
  AST_DT_SYNC: assert property (DT_OE |-> sync_m)
    else $error("data line driven outside sync master");
  AST_CK_IDLE: assert property (s_quiet ##1 s_quiet |-> TX_CK_OUT == ck_hi)
    else $error("idle clock level wrong");
  AST_DT_EDGE: assert property (DT_OE && $past(DT_OE) && $changed(DT_OUT)
    |-> TX_CK_OUT != ck_hi)
    else $error("data changed outside active clock half");
  AST_DT_HOLD: assert property (DT_OE && $changed(TX_CK_OUT) && TX_CK_OUT == ck_hi
    |-> $stable(DT_OUT))
    else $error("data moved at sampling edge");
  AST_BUSY: assert property (s_rd_busy |-> !RDATA[1])
    else $error("shifter empty while shifting");
  AST_EMPTY: assert property (s_rd_idle |-> RDATA[1])
    else $error("shifter not empty while idle");
endmodule : sbw_core_checker

bind sbw_core sbw_core_checker #(.DIV_W(DIV_W)) sbw_core_checker_i (
  .CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .RX_IN(RX_IN), .TX_CK_OUT(TX_CK_OUT), .TX_CK_OE(TX_CK_OE),
  .DT_OUT(DT_OUT), .DT_OE(DT_OE)
);

// file: sbw_defs.svh
// constants for the break, wake and synchronous master serial port
// assumes inclusion by bare name from the package and the core module
`ifndef SBW_DEFS_SVH
`define SBW_DEFS_SVH
// register indices on the plain register port
`define SBW_A_INT_FLAGS   4'h0
`define SBW_A_INT_ENABLES 4'h1
`define SBW_A_INT_PRIO    4'h2
`define SBW_A_RX_STATCTL  4'h3
`define SBW_A_RX_HOLDING  4'h4
`define SBW_A_TX_HOLDING  4'h5
`define SBW_A_TX_STATCTL  4'h6
`define SBW_A_BAUD_CTL    4'h7
`define SBW_A_BAUD_HI     4'h8
`define SBW_A_BAUD_LO     4'h9
// periph_int_flags fields
`define SBW_B_RX_FLAG    5
`define SBW_B_TX_FLAG    4
// rx_status_control fields
`define SBW_B_PORT_EN    7
`define SBW_B_RX9        6
`define SBW_B_SREN       5
`define SBW_B_CREN       4
`define SBW_B_ADDEN      3
`define SBW_B_FERR       2
`define SBW_B_RX9D       0
// tx_status_control fields
`define SBW_B_MASTER     7
`define SBW_B_TX9        6
`define SBW_B_TX_ON      5
`define SBW_B_SYNC       4
`define SBW_B_BRK        3
`define SBW_B_FAST       2
`define SBW_B_SH_EMPTY   1
`define SBW_B_NINTH_TRANSMIT_BIT       0
// baud_control fields
`define SBW_B_RX_IDLE    6
`define SBW_B_CK_HIGH    4
`define SBW_B_WIDE       3
`define SBW_B_WAKE       1
`define SBW_B_ABD        0
// reset values
`define SBW_RST_BYTE     8'h00
// async bit length in divisor ticks: plain, one speed bit, both
`define SBW_PRE_SLOW     5'h10
`define SBW_PRE_MID      5'h04
`define SBW_PRE_FAST     5'h01
// break data bits and frame lengths
`define SBW_BRK_BITS     4'hc
`define SBW_LEN8         4'h8
`define SBW_LEN9         4'h9
`endif

// file: sbw_node_model.sv
// bus node model: async frame listener, clocked slave, receive line driver
// assumes the bench sets the mode inputs while the lines are idle
`timescale 1ns/1ps
module sbw_node_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic       clk,
  input  wire logic       ck_line,
  input  wire logic       dt_line,
  input  wire logic       dt_oe,
  input  wire logic       sync_mode,
  input  wire logic       idle_high,
  input  wire logic [3:0] nbits,
  output logic            rx_line
);
  logic [12:0] async_q [$];
  logic [8:0]  sync_q [$];
  logic [12:0] aw;
  logic [8:0]  sw = 9'h000;
  logic [3:0]  cnt = 4'h0;
  logic        ck_s = 1'b1;
  initial rx_line = 1'b1;
  // async listener: 13 mid-bit samples span a break and its stop bit
  initial
  begin
    logic ck_d;
    ck_d = 1'b1;
    forever
    begin
      @(negedge clk);
      if (!sync_mode && ck_d && !ck_line)
      begin
        repeat (BIT_CLKS / 2) @(negedge clk);
        for (int i = 0; i < 13; i++)
        begin
          repeat (BIT_CLKS) @(negedge clk);
          aw[i] = ck_line;
        end
        async_q.push_back(aw);
      end
      ck_d = ck_line;
    end
  end
  // clocked slave: bit taken as the clock returns to its idle level
  always @(negedge clk)
  begin
    if (sync_mode && dt_oe && ck_s != idle_high && ck_line == idle_high)
    begin
      sw[cnt] = dt_line;
      cnt = cnt + 4'h1;
      if (cnt == nbits)
      begin
        sync_q.push_back(sw);
        sw = 9'h000;
        cnt = 4'h0;
      end
    end
    ck_s = ck_line;
  end
  // hold the receive line for n cycles, changed just after an edge
  task automatic drive_rx(input logic v, input int n);
    @(posedge clk);
    rx_line <= v;
    repeat (n - 1) @(posedge clk);
  endtask : drive_rx
  // one async byte: start, eight bits lsb first, stop
  task automatic send_rx(input logic [7:0] b);
    drive_rx(1'b0, BIT_CLKS);
    for (int i = 0; i < 8; i++)
      drive_rx(b[i], BIT_CLKS);
    drive_rx(1'b1, BIT_CLKS);
  endtask : send_rx
endmodule : sbw_node_model

// file: sbw_pkg.sv
// types shared by the serial port core
// assumes sbw_defs.svh is on the include path
package sbw_pkg;
  `include "sbw_defs.svh"
  typedef enum logic [1:0] {
    SBW_TX_IDLE  = 2'b00,
    SBW_TX_START = 2'b01,
    SBW_TX_DATA  = 2'b10,
    SBW_TX_STOP  = 2'b11
  } sbw_tx_e;
  typedef enum logic [1:0] {
    SBW_RX_IDLE  = 2'b00,
    SBW_RX_START = 2'b01,
    SBW_RX_DATA  = 2'b10,
    SBW_RX_STOP  = 2'b11
  } sbw_rx_e;
  typedef logic [7:0] sbw_byte_t;
endpackage : sbw_pkg

// file: tb_sbw_core.sv
// self-checking bench for the serial port core
// assumes core, checker bind and node model are compiled before it
`timescale 1ns/1ps
module tb_sbw_core;
  import sbw_pkg::*;
  logic       clk = 1'b0;
  logic       rstn;
  logic [3:0] addr;
  sbw_byte_t  wdata;
  sbw_byte_t  d;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       rx_in;
  logic       ck_out;
  logic       dt_out;
  logic       dt_oe;
  logic       sync_mode;
  logic       idle_high;
  logic [3:0] nbits;
  int         fails = 0;
  int         checks_done = 0;
  int         n;
  always #5 clk = ~clk;
  sbw_core sbw_core_i (
    .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RX_IN(rx_in), .TX_CK_OUT(ck_out), .TX_CK_OE(),
    .DT_OUT(dt_out), .DT_OE(dt_oe)
  );
  sbw_node_model sbw_node_model_i (
    .clk(clk), .ck_line(ck_out), .dt_line(dt_out), .dt_oe(dt_oe),
    .sync_mode(sync_mode), .idle_high(idle_high), .nbits(nbits), .rx_line(rx_in)
  );
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle strobes, changed just after the rising edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output sbw_byte_t v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    sbw_byte_t v;
    rd_reg(a, v);
    chk({5'h00, v}, {5'h00, e});
  endtask : rd_chk
  // bounded wait for the model to collect k frames
  task automatic wait_cnt(input bit use_sync, input int k);
    int i;
    i = 0;
    while ((use_sync ? sbw_node_model_i.sync_q.size() : sbw_node_model_i.async_q.size()) < k
      && i < 4000)
    begin
      @(posedge clk);
      i++;
    end
  endtask : wait_cnt
  // watchdog: whole run needs a few thousand cycles
  initial
  begin
    #500000;
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end
  initial
  begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    sync_mode = 1'b0;
    idle_high = 1'b1;
    nbits = 4'h8;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++)
      rd_chk(4'(i), 8'h00);
    rd_chk(4'h6, 8'h02);
    rd_chk(4'hf, 8'h00);
    wr_reg(4'h1, 8'h3c);
    wr_reg(4'h2, 8'hc3);
    rd_chk(4'h2, 8'hc3);
    wr_reg(4'h0, 8'hff);
    rd_chk(4'h0, 8'h00);
    $display("test registers done");
    wr_reg(4'h8, 8'h00);
    wr_reg(4'h9, 8'h0f);
    wr_reg(4'h7, 8'h08);
    wr_reg(4'h3, 8'h80);
    wr_reg(4'h6, 8'h2c);
    rd_chk(4'h0, 8'h10);
    wr_reg(4'h5, 8'hff);
    wr_reg(4'h5, 8'h55);
    rd_chk(4'h6, 8'h2c);
    rd_chk(4'h0, 8'h00);
    wait_cnt(1'b0, 2);
    chk(sbw_node_model_i.async_q[0], 13'h1000);
    chk(sbw_node_model_i.async_q[1], 13'h1f55);
    rd_chk(4'h6, 8'h26);
    rd_chk(4'h0, 8'h10);
    $display("test break done");
    sync_mode <= 1'b1;
    wr_reg(4'h7, 8'h18);
    wr_reg(4'h6, 8'h94);
    wr_reg(4'h6, 8'hb4);
    wr_reg(4'h5, 8'ha5);
    wr_reg(4'h5, 8'h3c);
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h6, 8'hb4);
    wait_cnt(1'b1, 2);
    chk({4'h0, sbw_node_model_i.sync_q[0]}, 13'h00a5);
    chk({4'h0, sbw_node_model_i.sync_q[1]}, 13'h003c);
    rd_chk(4'h0, 8'h10);
    wr_reg(4'h0, 8'h00);
    rd_chk(4'h0, 8'h10);
    repeat (40) @(posedge clk);
    rd_chk(4'h6, 8'hb6);
    idle_high <= 1'b0;
    nbits <= 4'h9;
    wr_reg(4'h7, 8'h08);
    wr_reg(4'h6, 8'hf5);
    wr_reg(4'h5, 8'h81);
    wait_cnt(1'b1, 3);
    chk({4'h0, sbw_node_model_i.sync_q[2]}, 13'h0181);
    $display("test sync master done");
    repeat (40) @(posedge clk);
    wr_reg(4'h6, 8'h20);
    repeat (4) @(posedge clk);
    sync_mode <= 1'b0;
    wr_reg(4'h9, 8'h03);
    wr_reg(4'h3, 8'h90);
    rd_chk(4'h7, 8'h48);
    wr_reg(4'h7, 8'h0a);
    sbw_node_model_i.drive_rx(1'b0, 20);
    rd_chk(4'h0, 8'h30);
    rd_chk(4'h7, 8'h4a);
    sbw_node_model_i.drive_rx(1'b1, 20);
    rd_chk(4'h7, 8'h48);
    rd_reg(4'h4, d);
    rd_chk(4'h0, 8'h10);
    sbw_node_model_i.send_rx(8'hc3);
    n = 0;
    do
    begin
      rd_reg(4'h0, d);
      n++;
    end
    while (d[5] !== 1'b1 && n < 50);
    chk({5'h00, d}, 13'h0030);
    rd_chk(4'h4, 8'hc3);
    rd_chk(4'h0, 8'h10);
    $display("test wake done");
    finish_test();
  end
endmodule : tb_sbw_core
